// ==== logic/rd_master_end.sv ====
// latency-aware read master: address phase, outstanding count, return capture fifo
// Notes on behaviour
// - may keep many reads outstanding at once
// - hold read, address, lanes while stalled
// - address taken on first unstalled edge
// - next request may follow immediately
// - fabric strobes valid one cycle per read
// - capture word on the valid edge
// - fabric returns words in request order
// - accept any latency, including zero
// - buffer returned words in a fifo
// - fabric may add extra latency
// - zero latency word arrives one edge after acceptance
// - flush cancels all outstanding reads
// - no valid after flush until new data
// - address accepted with flush returns next
// - non-latent master keeps one read outstanding
`default_nettype none
`include "rdport_defines.svh"
module rd_master_end (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    rdport_if.master bus,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire rdport_pkg::addr_t i_req_addr,
    input wire rdport_pkg::be_t i_req_be,
    input wire rdport_pkg::data_t i_req_wdata,
    input wire logic i_flush,
    input wire logic i_single,
    output logic o_req_ready,
    output logic o_rd_valid,
    output rdport_pkg::data_t o_rd_data,
    input wire logic i_rd_ready,
    output rdport_pkg::cnt_t o_pending
);
    import rdport_pkg::*;
    addr_state_e state_reg;
    data_t fifo_mem [`FIFO_DEPTH];
    logic [`FIFO_AW:0] wr_ptr_reg, rd_ptr_reg, fill;
    cnt_t pend_reg, pend_next;
    logic done, room, fifo_push, fifo_pop, start;
    assign done = (state_reg == ST_ADDR) & ~bus.waitrequest;
    assign fill = wr_ptr_reg - rd_ptr_reg;
    // room counts words in fifo plus reads that may still return, so nothing is dropped
    assign room = (32'(fill) + 32'(pend_reg) + (done & ~bus.write ? 32'd1 : 32'd0)) < `FIFO_DEPTH;
    // single mode waits for the previous word before issuing again
    assign start = i_req_valid & o_req_ready & (i_req_write | room) & ~(i_single & pend_next != '0);
    // a word arriving while flush stands on the link belongs to a cancelled read
    assign fifo_push = bus.readdatavalid & ~bus.flush;
    assign fifo_pop = o_rd_valid & i_rd_ready;
    // address phase; holds outputs while stalled, back to back when accepted
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            bus.read <= 1'b0;
            bus.write <= 1'b0;
            bus.address <= '0;
            bus.byteenable <= '0;
            bus.writedata <= '0;
        end else if (state_reg == ST_IDLE || done) begin
            if (start) begin
                state_reg <= ST_ADDR;
                bus.read <= ~i_req_write;
                bus.write <= i_req_write;
                bus.address <= i_req_addr;
                bus.byteenable <= i_req_be;
                bus.writedata <= i_req_wdata;
            end else begin
                state_reg <= ST_IDLE;
                bus.read <= 1'b0;
                bus.write <= 1'b0;
            end
        end
    end
    assign o_req_ready = 1'b1;
    // outstanding count
    always_comb begin
        pend_next = pend_reg;
        if (done & bus.read) pend_next = pend_next + 1'b1;
        if (bus.readdatavalid) pend_next = pend_next - 1'b1;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) pend_reg <= '0;
        else if (bus.flush) pend_reg <= (done & bus.read) ? 8'h01 : 8'h00;
        else pend_reg <= pend_next;
    end
    // flush goes out registered; count and fabric both act on the same link edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) bus.flush <= 1'b0;
        else bus.flush <= i_flush;
    end
    // return fifo
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (fifo_push) begin
                fifo_mem[wr_ptr_reg[`FIFO_AW-1:0]] <= bus.readdata;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (fifo_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
    // registered user outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
            o_pending <= '0;
        end else begin
            o_rd_valid <= (fill - (fifo_pop ? 3'd1 : 3'd0)) != 3'd0;
            o_rd_data <= fifo_mem[(fifo_pop ? rd_ptr_reg[`FIFO_AW-1:0] + 2'd1 : rd_ptr_reg[`FIFO_AW-1:0])];
            o_pending <= pend_reg;
        end
    end
endmodule // rd_master_end
`default_nettype wire

// ==== logic/rdport_defines.svh ====
// constants shared by the pipelined read port ends
`ifndef RDPORT_DEFINES_SVH
`define RDPORT_DEFINES_SVH
`define ADDR_W 32
`define DATA_W 32
`define BE_W 4
`define CNT_W 8
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define LAT_W 3
`define LAT_MAX 3'h3
`endif

// ==== logic/rdport_pkg.sv ====
// types shared by the pipelined read port ends
`default_nettype none
`include "rdport_defines.svh"
package rdport_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef logic [`BE_W-1:0] be_t;
    typedef logic [`CNT_W-1:0] cnt_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01
    } addr_state_e;
endpackage
`default_nettype wire

// ==== logic/rdport_if.sv ====
// link between the read master and the fabric end
`default_nettype none
interface rdport_if;
    import rdport_pkg::*;
    logic read;
    logic write;
    addr_t address;
    be_t byteenable;
    data_t writedata;
    logic waitrequest;
    logic readdatavalid;
    data_t readdata;
    logic flush;
    modport master (output read, output write, output address, output byteenable, output writedata,
                    output flush, input waitrequest, input readdatavalid, input readdata);
    modport fabric (input read, input write, input address, input byteenable, input writedata,
                    input flush, output waitrequest, output readdatavalid, output readdata);
endinterface
`default_nettype wire

// ==== logic/rd_fabric_end.sv ====
// fabric end: stalls, queues accepted reads, returns words in order after a latency
`default_nettype none
`include "rdport_defines.svh"
module rd_fabric_end (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    rdport_if.fabric bus,
    input wire logic i_stall,
    input wire logic [`LAT_W-1:0] i_latency,
    input wire rdport_pkg::data_t i_mem_data,
    output logic o_write_seen
);
    import rdport_pkg::*;
    addr_t q_addr [`FIFO_DEPTH];
    logic [`FIFO_AW:0] wr_ptr_reg, rd_ptr_reg;
    logic [`LAT_W-1:0] wait_reg;
    logic full, empty, accept, pop;
    assign full = (wr_ptr_reg - rd_ptr_reg) == 3'(`FIFO_DEPTH);
    assign empty = wr_ptr_reg == rd_ptr_reg;
    // stall when the queue is full or the test asks for it
    assign bus.waitrequest = i_stall | full;
    assign accept = (bus.read | bus.write) & ~bus.waitrequest;
    assign pop = ~empty & ~bus.flush & (wait_reg >= i_latency);
    // queue pointers; flush drops all pending reads but keeps a same-cycle accept
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (accept & bus.read) begin
                q_addr[wr_ptr_reg[`FIFO_AW-1:0]] <= bus.address;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (bus.flush) rd_ptr_reg <= (accept & bus.read) ? wr_ptr_reg : wr_ptr_reg;
            else if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1; // in order
        end
    end
    // added latency per word, restarting after each return
    always_ff @(posedge i_clk) begin
        if (i_sys_rst | pop | bus.flush) wait_reg <= '0;
        else if (~empty && wait_reg != `LAT_MAX) wait_reg <= wait_reg + 1'b1;
    end
    // one-cycle return strobe with the word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus.readdatavalid <= 1'b0;
            bus.readdata <= '0;
            o_write_seen <= 1'b0;
        end else begin
            bus.readdatavalid <= pop;
            bus.readdata <= i_mem_data ^ q_addr[rd_ptr_reg[`FIFO_AW-1:0]];
            o_write_seen <= accept & bus.write;
        end
    end
endmodule // rd_fabric_end
`default_nettype wire

// ==== sim/rdport_props.sv ====
// link checks for the read master and fabric pair
`default_nettype none
module rdport_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic read,
    input wire logic write,
    input wire rdport_pkg::addr_t address,
    input wire rdport_pkg::be_t byteenable,
    input wire logic waitrequest,
    input wire logic flush,
    input wire logic readdatavalid
);
    import rdport_pkg::*;
    logic [3:0] owed_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_stall; read && waitrequest; endsequence
    sequence s_take; read && !waitrequest; endsequence
    // words the fabric still owes; flush drops all but a read taken on the same edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) owed_reg <= 4'h0;
        else if (flush) owed_reg <= {3'h0, read && !waitrequest};
        else owed_reg <= owed_reg + {3'h0, read && !waitrequest} - {3'h0, readdatavalid};
    end
    a_stall_hold_req: assert property (s_stall |=> read && $stable(address) && $stable(byteenable))
        else $error("read moved in stall");
    a_write_hold: assert property (write && waitrequest |=> write && $stable(address))
        else $error("write moved in stall");
    a_stall_ends: assert property (s_stall |-> ##[0:40] s_take)
        else $error("read never taken");
    a_no_orphan: assert property (readdatavalid |-> owed_reg != 4'h0)
        else $error("word with none owed");
    a_return_due: assert property (owed_reg != 4'h0 |-> ##[0:20] readdatavalid)
        else $error("word overdue");
    a_depth_cap: assert property (owed_reg <= 4'h4)
        else $error("too many owed");
    a_rw_apart: assert property (!(read && write))
        else $error("read and write at once");
    a_idle_quiet: assert property (owed_reg == 4'h0 && !read |=> !readdatavalid)
        else $error("valid while idle");
endmodule // rdport_props
`default_nettype wire

// ==== sim/pipelined_read_master_port_test.sv ====
// self-checking bench for the read master and fabric pair
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("mismatch %0t %h %h", $time, g, e); end end
module pipelined_read_master_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rdport_pkg::*;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_flush = 1'b0, i_stall = 1'b0, o_rd_valid;
    logic [2:0] i_latency = 3'h0;
    addr_t i_req_addr = 32'h0;
    data_t i_mem_data = 32'h5a5a_0f0f, o_rd_data;
    cnt_t o_pending;
    int n_errors = 0, tests_run = 0, cyc = 0;
    // rows: latency, stall, address; the word expected back is memory xor address
    logic [35:0] rows [4] = '{{3'h0, 1'h0, 32'h10}, {3'h3, 1'h1, 32'hffff_fffc},
        {3'h1, 1'h1, 32'h4}, {3'h2, 1'h0, 32'h8}};
    rdport_if link ();
    rd_master_end u_rd_master_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(link), .i_req_valid(i_req_valid),
        .i_req_write(1'b0), .i_req_addr(i_req_addr), .i_req_be(4'hf), .i_req_wdata(32'h0), .i_flush(i_flush),
        .i_single(1'b0), .o_req_ready(), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(1'b1),
        .o_pending(o_pending));
    rd_fabric_end u_rd_fabric_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(link), .i_stall(i_stall),
        .i_latency(i_latency), .i_mem_data(i_mem_data), .o_write_seen());
    rdport_props u_rdport_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .read(link.read), .write(link.write),
        .address(link.address), .byteenable(link.byteenable), .waitrequest(link.waitrequest), .flush(link.flush),
        .readdatavalid(link.readdatavalid));
    always #5 i_clk = ~i_clk;
    // hang guard: the whole run needs about a hundred cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // raise a request at this edge; the caller drops valid so back-to-back stays clean
    task automatic send(input addr_t a);
        i_req_valid <= 1'b1;
        i_req_addr <= a;
        @(posedge i_clk);
    endtask
    // the word stands one cycle only, so it is watched at every falling edge
    task automatic expect_word(input addr_t a);
        int n;
        n = 0;
        @(negedge i_clk);
        while (o_rd_valid !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        `CHK(o_rd_data, i_mem_data ^ a)
        @(posedge i_clk);
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        `CHK({o_rd_valid, o_pending}, 9'h0)
        foreach (rows[k]) begin
            @(posedge i_clk);
            {i_latency, i_stall} <= rows[k][35:32];
            send(rows[k][31:0]);
            i_req_valid <= 1'b0;
            repeat (2 * rows[k][32]) @(posedge i_clk);
            i_stall <= 1'b0;
            expect_word(rows[k][31:0]);
        end
        // three reads on consecutive edges, answered in request order
        i_latency <= 3'h3;
        for (int k = 1; k <= 3; k++) send(32'h100 * k);
        i_req_valid <= 1'b0;
        for (int k = 1; k <= 3; k++) expect_word(32'h100 * k);
        // flush together with a new read: only the new word may come back
        send(32'h200);
        send(32'h300);
        i_flush <= 1'b1;
        send(32'h400);
        i_flush <= 1'b0;
        i_req_valid <= 1'b0;
        expect_word(32'h400);
        repeat (4) @(posedge i_clk);
        `CHK(o_pending, 8'h0)
        stop_test();
    end
endmodule // pipelined_read_master_port_test
`default_nettype wire
